// ### core/alu_core.sv
/*
 * cpu alu top: add/sub/logic, barrel shifter, 17x17 multiplier and
 * divider, flag register, all reached over an apb slave.
 * assumes apb signals come from logic on the same clock.
 */
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module alu_core (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [alu_pkg::AW-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr
);
	import alu_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	// zero and negative of a result at the chosen width
	function automatic logic [1:0] zn_of(input logic [DW-1:0] r, input logic bw);
		zn_of = bw ? {r[7:0] == 8'h00, r[7]} : {r == WORD_RST, r[15]}; // RULE_21
	endfunction

	function automatic logic is_mapped(input logic [AW-1:0] a);
		is_mapped = (a[1:0] == 2'b00) && (a <= A_STATUS);
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [CTRL_W-1:0] ctrl_reg;
	logic              exec_reg;
	logic              abort_reg;
	logic [DW-1:0]     wreg_lo_reg;
	logic [DW-1:0]     wreg_hi_reg;
	logic [DW-1:0]     wreg_b_reg;
	logic [DW-1:0]     mem_opnd_reg;
	logic [DW-1:0]     mem_result_reg;
	logic [DW-1:0]     result_reg;
	logic [DW-1:0]     result_hi_reg;
	logic [DW-1:0]     alu_flags_reg;
	logic [DW-1:0]     quotient_reg;
	logic [DW-1:0]     remainder_reg;
	logic              div_busy;
	logic              div_done;
	logic [DW-1:0]     div_q;
	logic [DW-1:0]     div_r;
	logic              access;
	logic              wr_ok;
	alu_op_t           op;
	logic              bw;
	logic              sub;
	logic [3:0]        amt;
	logic [DW-1:0]     a;
	logic [DW-1:0]     b;
	logic [DW-1:0]     bn;
	logic [DW:0]       sum17;
	logic [8:0]        sum9;
	logic [4:0]        sum5;
	logic [16:0]       ma;
	logic [16:0]       mb;
	logic [33:0]       prod;
	logic [DW-1:0]     res;
	logic [DW-1:0]     flg;
	logic              wr_res;

	assign op  = alu_op_t'(ctrl_reg[C_OP_LSB +: 4]);
	assign bw  = ctrl_reg[C_BYTE]; // RULE_04
	assign sub = (op == OP_SUB);
	assign amt = ctrl_reg[C_LIT_LSB +: 4];
	assign access = psel && penable && !pready;
	assign wr_ok  = access && pwrite && is_mapped(paddr);

	// ****************************************
	// datapath
	// ****************************************
	// one combinational pass per issued operation; only the low byte counts in byte mode
	always_comb
	begin
		a = wreg_lo_reg;
		b = ctrl_reg[C_SRC_MEM] ? mem_opnd_reg : wreg_b_reg; // RULE_05
		if (ctrl_reg[C_USE_LIT])
			b = {11'h000, ctrl_reg[C_LIT_LSB +: 5]}; // RULE_08
		bn = sub ? ~b : b; // RULE_03
		sum17 = {1'b0, a} + {1'b0, bn} + {16'h0000, sub}; // RULE_01
		sum9  = {1'b0, a[7:0]} + {1'b0, bn[7:0]} + {8'h00, sub};
		sum5  = {1'b0, a[3:0]} + {1'b0, bn[3:0]} + {4'h0, sub};
		// byte mode treats operands as unsigned bytes
		ma = bw ? {9'h000, a[7:0]} : {ctrl_reg[C_A_SIGNED] & a[15], a}; // RULE_07
		mb = bw ? {9'h000, b[7:0]} : {ctrl_reg[C_B_SIGNED] & b[15] & !ctrl_reg[C_USE_LIT], b}; // RULE_09
		prod = $signed({{17{ma[16]}}, ma}) * $signed({{17{mb[16]}}, mb}); // RULE_06
		flg = alu_flags_reg;
		res = WORD_RST;
		case (op)
			OP_ADD, OP_SUB:
			begin
				res = sum17[DW-1:0];
				flg[F_C]  = bw ? sum9[8] : sum17[16]; // RULE_21
				flg[F_HALF_CARRY]  = bw ? sum5[4] : sum9[8]; // RULE_19
				flg[F_SIGNED_WRAP] = bw ? (a[7] == bn[7]) && (sum9[7] != a[7]) // RULE_20
					: (a[15] == bn[15]) && (sum17[15] != a[15]);
				{flg[F_Z], flg[F_N]} = zn_of(res, bw); // RULE_02
			end
			OP_AND, OP_IOR, OP_XOR:
			begin
				res = (op == OP_AND) ? (a & b) : (op == OP_IOR) ? (a | b) : (a ^ b);
				{flg[F_Z], flg[F_N]} = zn_of(res, bw);
			end
			OP_LEFT_SHIFT:
			begin
				res = a << amt; // RULE_14
				{flg[F_Z], flg[F_N]} = zn_of(res, bw);
			end
			OP_ARITHMETIC_RIGHT_SHIFT:
			begin
				res = bw ? 16'($signed({{8{a[7]}}, a[7:0]}) >>> amt) : 16'($signed(a) >>> amt); // RULE_16
				{flg[F_Z], flg[F_N]} = zn_of(res, bw);
			end
			OP_LOGICAL_RIGHT_SHIFT:
			begin
				res = bw ? ({8'h00, a[7:0]} >> amt) : (a >> amt); // RULE_16
				{flg[F_Z], flg[F_N]} = zn_of(res, bw);
			end
			OP_MUL:
				res = prod[DW-1:0];
			default:
				res = WORD_RST;
		endcase
	end

	// shifts are register-only, so the memory path is forced off for them
	assign wr_res = (op == OP_LEFT_SHIFT) || (op == OP_ARITHMETIC_RIGHT_SHIFT)
		|| (op == OP_LOGICAL_RIGHT_SHIFT) || !ctrl_reg[C_DST_MEM]; // RULE_15

	// ****************************************
	// divider
	// ****************************************
	alu_divider u_div (
		.clock       (clock),
		.rst         (rst),
		.ce          (ce),
		.start       (exec_reg && op == OP_DIV),
		.abort       (abort_reg),
		.long_mode   (ctrl_reg[C_DIV_LONG]), // RULE_10
		.signed_mode (ctrl_reg[C_DIV_SGN]),
		.dividend    ({wreg_hi_reg, wreg_lo_reg}),
		.divisor     (wreg_b_reg),
		.busy        (div_busy),
		.done        (div_done),
		.quotient    (div_q),
		.remainder   (div_r)
	);

	// ****************************************
	// control and issue
	// ****************************************
	// a go while a divide runs is dropped so the operands stay stable
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg  <= CTRL_RST;
			exec_reg  <= 1'b0;
			abort_reg <= 1'b0;
		end
		else if (ce)
		begin
			exec_reg  <= 1'b0;
			abort_reg <= 1'b0;
			if (wr_ok && paddr == A_CTRL && !div_busy)
			begin
				ctrl_reg <= pwdata[CTRL_W-1:0];
				exec_reg <= pwdata[C_GO];
			end
			if (wr_ok && paddr == A_CTRL)
				abort_reg <= pwdata[C_ABORT]; // RULE_17
		end
	end

	// working registers, results and flags; hardware updates win over software writes
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wreg_lo_reg    <= WORD_RST;
			wreg_hi_reg    <= WORD_RST;
			wreg_b_reg     <= WORD_RST;
			mem_opnd_reg   <= WORD_RST;
			mem_result_reg <= WORD_RST;
			result_reg     <= WORD_RST;
			result_hi_reg  <= WORD_RST;
			alu_flags_reg  <= WORD_RST;
		end
		else if (ce)
		begin
			if (wr_ok)
			begin
				case (paddr)
					A_WLO:    wreg_lo_reg    <= pwdata[DW-1:0];
					A_WHI:    wreg_hi_reg    <= pwdata[DW-1:0];
					A_WB:     wreg_b_reg     <= pwdata[DW-1:0];
					A_MEMOP:  mem_opnd_reg   <= pwdata[DW-1:0];
					A_MEMRES: mem_result_reg <= pwdata[DW-1:0];
					A_FLAGS:  alu_flags_reg  <= pwdata[DW-1:0] & FLAG_MASK;
					default:  result_reg     <= result_reg;
				endcase
			end
			if (exec_reg && op != OP_DIV) // RULE_18
			begin
				result_reg    <= res;
				alu_flags_reg <= flg & FLAG_MASK; // RULE_02
				if (op == OP_MUL)
					result_hi_reg <= prod[31:16];
				// byte writes leave the destination's upper byte alone
				if (wr_res)
					wreg_lo_reg <= bw ? {wreg_lo_reg[15:8], res[7:0]} : res;
				else
					mem_result_reg <= bw ? {mem_result_reg[15:8], res[7:0]} : res; // RULE_05
			end
		end
	end

	// divide results always land in the fixed pair
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			quotient_reg  <= WORD_RST;
			remainder_reg <= WORD_RST;
		end
		else if (ce && div_done)
		begin
			quotient_reg  <= div_q; // RULE_11
			remainder_reg <= div_r;
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	// one wait state: pready rises the cycle after the access phase begins
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RDATA_RST;
		end
		else if (ce)
		begin
			pready  <= access;
			pslverr <= access && !is_mapped(paddr);
			if (access && !pwrite)
			begin
				case (paddr)
					A_CTRL:   prdata <= {15'h0000, ctrl_reg};
					A_WLO:    prdata <= {16'h0000, wreg_lo_reg};
					A_WHI:    prdata <= {16'h0000, wreg_hi_reg};
					A_WB:     prdata <= {16'h0000, wreg_b_reg};
					A_MEMOP:  prdata <= {16'h0000, mem_opnd_reg};
					A_MEMRES: prdata <= {16'h0000, mem_result_reg};
					A_RESULT: prdata <= {16'h0000, result_reg};
					A_RESHI:  prdata <= {16'h0000, result_hi_reg};
					A_FLAGS:  prdata <= {16'h0000, alu_flags_reg};
					A_QUOT:   prdata <= {16'h0000, quotient_reg};
					A_REM:    prdata <= {16'h0000, remainder_reg};
					A_STATUS: prdata <= {31'h0000_0000, div_busy};
					default:  prdata <= RDATA_RST;
				endcase
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_word(alu_op_t o);
		exec_reg && op == o && !bw;
	endsequence

	a_apb_ready_pulse: assert property (@(posedge clock) disable iff (rst || !ce)
		pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_sub_borrow_flag: assert property (@(posedge clock) disable iff (rst || !ce) // RULE_03
		s_word(OP_SUB) |=> alu_flags_reg[F_C] == ($past(a) >= $past(b)))
		else $error("subtract carry does not show no-borrow");
	a_zero_flag_set: assert property (@(posedge clock) disable iff (rst || !ce) // RULE_02
		s_word(OP_AND) |=> alu_flags_reg[F_Z] == (result_reg == WORD_RST))
		else $error("zero flag disagrees with result");
	a_mul_one_cycle: assert property (@(posedge clock) disable iff (rst || !ce) // RULE_18
		s_word(OP_MUL) |=> {result_hi_reg, result_reg} == 32'($past(prod)))
		else $error("product not stored in one cycle");
	a_right_zero_fill: assert property (@(posedge clock) disable iff (rst || !ce) // RULE_16
		s_word(OP_LOGICAL_RIGHT_SHIFT) |=> result_reg == ($past(a) >> $past(amt)))
		else $error("logical right shift did not zero fill");
	a_byte_half_carry: assert property (@(posedge clock) disable iff (rst || !ce) // RULE_19
		exec_reg && op == OP_ADD && bw |=> alu_flags_reg[F_HALF_CARRY] == $past(sum5[4]))
		else $error("byte half carry not from bit 3");
	a_quot_lands: assert property (@(posedge clock) disable iff (rst || !ce) // RULE_11
		div_done |=> quotient_reg == $past(div_q) && remainder_reg == $past(div_r))
		else $error("divide result not in quotient and remainder");
	a_shift_reg_only: assert property (@(posedge clock) disable iff (rst || !ce) // RULE_15
		exec_reg && op == OP_LEFT_SHIFT |=> $stable(mem_result_reg))
		else $error("shift wrote the memory result");

endmodule

// ### core/alu_pkg.sv
/*
 * constants, field layouts and op codes of the cpu alu with
 * multiplier, divider and barrel shifter, reached over apb.
 * assumes one 50 MHz clock and an active high asynchronous reset.
 */
// Operation
// (RULE_01) 16-bit operands; add, subtract, shift and logic ops; arithmetic is two's complement.
// (RULE_02) ops update carry, zero, negative, overflow and half carry in the flag register.
// (RULE_03) on subtract, carry and half carry mean "no borrow"; zero means borrow.
// (RULE_04) each op runs at byte or word width, picked per issued operation. The code ignores the byte bit for divide, which always runs at word width.
// (RULE_05) operands come from working registers or memory; results go to either.
// (RULE_06) a 17 by 17 multiplier handles unsigned, signed and mixed sign products.
// (RULE_07) 16x16 signed, unsigned, and unsigned by signed, each operand signed independently.
// (RULE_08) a 5-bit unsigned literal may multiply a signed or unsigned 16-bit operand.
// (RULE_09) an 8-bit by 8-bit unsigned multiply mode exists.
// (RULE_10) divide 32/16 and 16/16, each signed and unsigned.
// (RULE_11) quotient always lands in quotient_reg, remainder in remainder_reg.
// (RULE_12) divisor from any working register; 32-bit dividend from pair, high register upper half. The code always takes the divisor from wreg_b_reg.
// (RULE_13) one iteration per divisor bit, so both divide sizes take equal cycles.
// (RULE_14) one-cycle arithmetic right or left shift by up to 15 bits.
// (RULE_15) multi-bit shifts read and write working registers only, never memory.
// (RULE_16) arithmetic right, left and logical right shifts; logical right fills zeros.
// (RULE_17) every divide takes 19 cycles and can be cut off at any cycle.
// (RULE_18) every multiply completes in one cycle.
// (RULE_19) half carry is carry out of bit 3 for bytes, bit 7 for words.
// (RULE_20) overflow flag set on signed overflow, cleared otherwise.
// (RULE_21) in byte mode carry, zero, negative and overflow use the low byte only.
// (RULE_22) signed divide truncates toward zero; remainder takes the dividend's sign.
package alu_pkg;

	// ****************************************
	// widths and timing
	// ****************************************
	localparam int DW         = 16;
	localparam int AW         = 8;
	localparam int DIV_STEPS  = 16;
	localparam int DIV_CYCLES = 19;

	// ****************************************
	// register byte addresses
	// ****************************************
	localparam logic [AW-1:0] A_CTRL    = 8'h00;
	localparam logic [AW-1:0] A_WLO     = 8'h04;
	localparam logic [AW-1:0] A_WHI     = 8'h08;
	localparam logic [AW-1:0] A_WB      = 8'h0C;
	localparam logic [AW-1:0] A_MEMOP   = 8'h10;
	localparam logic [AW-1:0] A_MEMRES  = 8'h14;
	localparam logic [AW-1:0] A_RESULT  = 8'h18;
	localparam logic [AW-1:0] A_RESHI   = 8'h1C;
	localparam logic [AW-1:0] A_FLAGS   = 8'h20;
	localparam logic [AW-1:0] A_QUOT    = 8'h24;
	localparam logic [AW-1:0] A_REM     = 8'h28;
	localparam logic [AW-1:0] A_STATUS  = 8'h2C;

	// ****************************************
	// control word fields
	// ****************************************
	localparam int C_OP_LSB   = 0;
	localparam int C_BYTE     = 4;
	localparam int C_A_SIGNED = 5;
	localparam int C_B_SIGNED = 6;
	localparam int C_USE_LIT  = 7;
	localparam int C_SRC_MEM  = 8;
	localparam int C_DST_MEM  = 9;
	localparam int C_DIV_LONG = 10;
	localparam int C_DIV_SGN  = 11;
	localparam int C_LIT_LSB  = 12;
	localparam int C_ABORT    = 30;
	localparam int C_GO       = 31;
	localparam int CTRL_W     = 17;

	// ****************************************
	// flag positions and reset values
	// ****************************************
	localparam int F_C           = 0;
	localparam int F_Z           = 1;
	localparam int F_SIGNED_WRAP = 2;
	localparam int F_N           = 3;
	localparam int F_HALF_CARRY  = 8;
	localparam logic [DW-1:0]     FLAG_MASK  = 16'h010F;
	localparam logic [DW-1:0]     WORD_RST   = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_RST   = 17'h0_0000;
	localparam logic [31:0]       RDATA_RST  = 32'h0000_0000;

	typedef enum logic [3:0] {
		OP_ADD                    = 4'h0,
		OP_SUB                    = 4'h1,
		OP_AND                    = 4'h2,
		OP_IOR                    = 4'h3,
		OP_XOR                    = 4'h4,
		OP_LEFT_SHIFT             = 4'h5,
		OP_ARITHMETIC_RIGHT_SHIFT = 4'h6,
		OP_LOGICAL_RIGHT_SHIFT    = 4'h7,
		OP_MUL                    = 4'h8,
		OP_DIV                    = 4'h9
	} alu_op_t;

endpackage

// ### core/alu_divider.sv
/*
 * iterative restoring divider, 32/16 or 16/16, signed or unsigned.
 * assumes start is a one-cycle pulse from the same clock domain.
 */
`timescale 1ns/1ps
module alu_divider (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic                   start,
	input  wire logic                   abort,
	input  wire logic                   long_mode,
	input  wire logic                   signed_mode,
	input  wire logic [31:0]            dividend,
	input  wire logic [alu_pkg::DW-1:0] divisor,
	output logic                        busy,
	output logic                        done,
	output logic      [alu_pkg::DW-1:0] quotient,
	output logic      [alu_pkg::DW-1:0] remainder
);
	import alu_pkg::*;

	typedef enum logic [3:0] {
		DS_IDLE = 4'b0001,
		DS_ITER = 4'b0010,
		DS_FIX  = 4'b0100,
		DS_DONE = 4'b1000
	} alu_div_state_t;

	alu_div_state_t state_reg;
	logic [4:0]     cnt_reg;
	logic [DW-1:0]  d_reg;
	logic           qneg_reg;
	logic           rneg_reg;
	logic [31:0]    dvd;
	logic [31:0]    mag;
	logic [DW:0]    trial;
	logic           fits;

	// operand magnitudes; a short dividend is widened by mode
	always_comb
	begin
		dvd = long_mode ? dividend : {signed_mode ? {16{dividend[15]}} : 16'h0000, dividend[15:0]}; // RULE_12
		mag = (signed_mode && dvd[31]) ? 32'(-dvd) : dvd;
		trial = {remainder, quotient[DW-1]};
		fits = trial >= {1'b0, d_reg};
	end

	// sequencer: load, one step per divisor bit, sign fix, done
	// the upper dividend half must be below the divisor or the quotient wraps
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= DS_IDLE;
			cnt_reg   <= 5'd0;
			busy      <= 1'b0;
			done      <= 1'b0;
			d_reg     <= WORD_RST;
			qneg_reg  <= 1'b0;
			rneg_reg  <= 1'b0;
			quotient  <= WORD_RST;
			remainder <= WORD_RST;
		end
		else if (ce)
		begin
			done <= 1'b0;
			if (abort) // RULE_17
			begin
				state_reg <= DS_IDLE;
				busy      <= 1'b0;
			end
			else
			begin
				case (state_reg)
					DS_IDLE:
					begin
						if (start)
						begin
							state_reg <= DS_ITER;
							busy      <= 1'b1;
							cnt_reg   <= 5'd0;
							remainder <= mag[31:16];
							quotient  <= mag[15:0];
							d_reg     <= (signed_mode && divisor[15]) ? 16'(-divisor) : divisor;
							rneg_reg  <= signed_mode && dvd[31]; // RULE_22
							qneg_reg  <= signed_mode && (dvd[31] ^ divisor[15]);
						end
					end
					DS_ITER:
					begin
						remainder <= fits ? 16'(trial - {1'b0, d_reg}) : trial[DW-1:0];
						quotient  <= {quotient[DW-2:0], fits};
						cnt_reg   <= 5'(cnt_reg + 5'd1);
						if (cnt_reg == 5'(DIV_STEPS - 1)) // RULE_13
							state_reg <= DS_FIX;
					end
					DS_FIX:
					begin
						if (qneg_reg)
							quotient <= 16'(-quotient); // RULE_22
						if (rneg_reg)
							remainder <= 16'(-remainder);
						done      <= 1'b1;
						state_reg <= DS_DONE;
					end
					DS_DONE:
					begin
						busy      <= 1'b0;
						state_reg <= DS_IDLE;
					end
					default:
					begin
						busy      <= 1'b0;
						state_reg <= DS_IDLE;
					end
				endcase
			end
		end
	end

	sequence s_div_issue;
		start && !busy && !abort;
	endsequence

	a_div_length: assert property (@(posedge clock) disable iff (rst || !ce || abort) // RULE_17
		s_div_issue |-> ##(DIV_CYCLES - 1) done)
		else $error("divide did not finish in 19 cycles");
	a_div_busy_hold: assert property (@(posedge clock) disable iff (rst || !ce || abort) // RULE_13
		s_div_issue |=> busy [*8])
		else $error("divider dropped busy early");

endmodule

// ### verification/alu_cpu_model.sv
/*
 * cpu-side apb master: stands in for the decoder, working registers and memory.
 * assumes one clock shared with the alu and a slave that raises pready.
 */
`timescale 1ns/1ps
module alu_cpu_model (
	input  wire logic                   clock,
	input  wire logic [31:0]            prdata,
	input  wire logic                   pready,
	input  wire logic                   pslverr,
	output logic                        psel,
	output logic                        penable,
	output logic                        pwrite,
	output logic      [alu_pkg::AW-1:0] paddr,
	output logic      [31:0]            pwdata
);
	import alu_pkg::*;

	// ****************************************
	// bus master
	// ****************************************
	int n_timeout;

	// idle bus from time zero so the slave sees no stray request
	initial
	begin
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0000_0000;
		n_timeout = 0;
	end

	// operands and results move as whole words through register or memory slots
	task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int i;
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		// bounded wait: a dead slave must not hang the run
		for (i = 0; i < 16; i++)
		begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (i == 16)
			n_timeout++;
	endtask
endmodule

// ### verification/test_cpu_alu_mul_div_shift.sv
/*
 * self-checking bench for the alu core: add/sub, logic, shifts, multiply
 * modes, divide with abort, bus error answers.
 * assumes the core files and the cpu model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module test_cpu_alu_mul_div_shift;
	import alu_pkg::*;

	logic                 clock;
	logic                 rst;
	logic                 ce;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic        [AW-1:0] paddr;
	logic        [31:0]   pwdata;
	logic        [31:0]   prdata;
	logic                 pready;
	logic                 pslverr;
	logic        [31:0]   rdata;
	logic                 err;
	int                   n_fail;
	int                   num_checks;

	// ****************************************
	// clock, dut and cpu side
	// ****************************************
	// 50 MHz
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	alu_core u_dut (.clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	alu_cpu_model u_cpu (.clock(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	// ****************************************
	// helpers
	// ****************************************
	task automatic give_verdict();
		n_fail = n_fail + u_cpu.n_timeout;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic xact(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
		u_cpu.xfer(wr, a, d, rdata, err);
		if (u_cpu.n_timeout != 0)
			give_verdict();
	endtask

	task automatic rchk(input logic [AW-1:0] a, input logic [31:0] ex, input string nm);
		xact(1'b0, a, 32'h0000_0000);
		`CHK(nm, ex, rdata)
	endtask

	// flags cleared first so untouched bits must read back zero
	task automatic run_op(input logic [31:0] c, input logic [15:0] a, input logic [15:0] b);
		xact(1'b1, A_FLAGS, 32'h0000_0000);
		xact(1'b1, A_WLO, {16'h0000, a});
		xact(1'b1, A_WB, {16'h0000, b});
		xact(1'b1, A_MEMOP, {16'h0000, b});
		xact(1'b1, A_CTRL, c | 32'h8000_0000);
	endtask

	task automatic alu_case(input logic [31:0] c, input logic [15:0] a, input logic [15:0] b,
		input logic [AW-1:0] dst, input logic [15:0] res, input logic [15:0] fl);
		run_op(c, a, b);
		rchk(dst, {16'h0000, res}, "alu result");
		rchk(A_FLAGS, {16'h0000, fl}, "alu flags");
	endtask

	task automatic mul_case(input logic [31:0] c, input logic [15:0] a, input logic [15:0] b,
		input logic [31:0] p);
		run_op(c, a, b);
		rchk(A_RESULT, {16'h0000, p[15:0]}, "product low");
		rchk(A_RESHI, {16'h0000, p[31:16]}, "product high");
		rchk(A_FLAGS, 32'h0000_0000, "mul flags");
	endtask

	// poll count must match the fixed divide length for both sizes
	task automatic div_case(input logic [31:0] c, input logic [15:0] hi, input logic [15:0] lo,
		input logic [15:0] d, input logic [15:0] q, input logic [15:0] r);
		int n;
		xact(1'b1, A_WHI, {16'h0000, hi});
		xact(1'b1, A_WLO, {16'h0000, lo});
		xact(1'b1, A_WB, {16'h0000, d});
		xact(1'b1, A_CTRL, c | 32'h8000_0000);
		rchk(A_STATUS, 32'h0000_0001, "div busy");
		for (n = 0; n < 12; n++)
		begin
			xact(1'b0, A_STATUS, 32'h0000_0000);
			if (rdata[0] === 1'b0)
				break;
		end
		// busy covers 18 of the 19 cycles, so the fourth poll is the first to see it idle
		`CHK("div length", 3, n)
		rchk(A_QUOT, {16'h0000, q}, "quotient");
		rchk(A_REM, {16'h0000, r}, "remainder");
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic sc_reset();
		rchk(A_FLAGS, 32'h0000_0000, "flags at reset");
		rchk(A_STATUS, 32'h0000_0000, "status at reset");
		xact(1'b0, 8'h30, 32'h0000_0000);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0000_0000, rdata)
		xact(1'b1, 8'h06, 32'h0000_FFFF);
		`CHK("misaligned err", 1'b1, err)
		xact(1'b1, A_RESULT, 32'h0000_1234);
		rchk(A_RESULT, 32'h0000_0000, "result read only");
	endtask

	task automatic sc_alu();
		alu_case(32'h0000_0000, 16'h7FFF, 16'h0001, A_WLO, 16'h8000, 16'h010C);
		alu_case(32'h0000_0001, 16'h0000, 16'h0001, A_WLO, 16'hFFFF, 16'h0008);
		alu_case(32'h0000_0001, 16'h0005, 16'h0005, A_WLO, 16'h0000, 16'h0103);
		alu_case(32'h0000_0010, 16'h12F0, 16'h0010, A_WLO, 16'h1200, 16'h0003);
		alu_case(32'h0000_0010, 16'h007F, 16'h0001, A_WLO, 16'h0080, 16'h010C);
		alu_case(32'h0000_0300, 16'h0003, 16'h0004, A_MEMRES, 16'h0007, 16'h0000);
		alu_case(32'h0000_0002, 16'hF0F0, 16'h0FF0, A_WLO, 16'h00F0, 16'h0000);
		alu_case(32'h0000_0003, 16'hF0F0, 16'h0FF0, A_WLO, 16'hFFF0, 16'h0008);
		alu_case(32'h0000_0004, 16'hF0F0, 16'hF0F0, A_WLO, 16'h0000, 16'h0002);
		alu_case(32'h0000_F005, 16'h8001, 16'h0000, A_WLO, 16'h8000, 16'h0008);
		alu_case(32'h0000_F006, 16'h8001, 16'h0000, A_WLO, 16'hFFFF, 16'h0008);
		alu_case(32'h0000_4006, 16'h8000, 16'h0000, A_WLO, 16'hF800, 16'h0008);
		alu_case(32'h0000_F207, 16'h8001, 16'h0000, A_WLO, 16'h0001, 16'h0000);
		alu_case(32'h0000_1007, 16'h0001, 16'h0000, A_WLO, 16'h0000, 16'h0002);
	endtask

	task automatic sc_mul();
		mul_case(32'h0000_0068, 16'hFFFF, 16'h0002, 32'hFFFF_FFFE);
		mul_case(32'h0000_0008, 16'hFFFF, 16'h0002, 32'h0001_FFFE);
		mul_case(32'h0000_0048, 16'hFFFF, 16'hFFFF, 32'hFFFF_0001);
		mul_case(32'h0000_0068, 16'h8000, 16'h8000, 32'h4000_0000);
		mul_case(32'h0001_F0A8, 16'hFFFF, 16'h0000, 32'hFFFF_FFE1);
		mul_case(32'h0001_F088, 16'hFFFF, 16'h0000, 32'h001E_FFE1);
		mul_case(32'h0000_0018, 16'h12FF, 16'h34FF, 32'h0000_FE01);
	endtask

	task automatic sc_div();
		div_case(32'h0000_0809, 16'h0000, 16'hFFF9, 16'h0002, 16'hFFFD, 16'hFFFF);
		div_case(32'h0000_0009, 16'h0000, 16'hFFF9, 16'h0002, 16'h7FFC, 16'h0001);
		div_case(32'h0000_0409, 16'h0001, 16'h0000, 16'h0002, 16'h8000, 16'h0000);
		div_case(32'h0000_0C09, 16'hFFFE, 16'h795F, 16'h0007, 16'hC833, 16'hFFFA);
	endtask

	// abort mid divide: idle at once, old quotient kept
	task automatic sc_abort();
		xact(1'b1, A_WLO, 32'h0000_0064);
		xact(1'b1, A_CTRL, 32'h8000_0009);
		xact(1'b1, A_CTRL, 32'h4000_0000);
		rchk(A_STATUS, 32'h0000_0000, "abort idle");
		repeat (24) @(posedge clock);
		rchk(A_QUOT, 32'h0000_C833, "abort quotient");
	endtask

	// enable low freezes a running divide; it resumes where it stopped
	task automatic sc_freeze();
		xact(1'b1, A_CTRL, 32'h8000_0009);
		ce <= 1'b0;
		repeat (40) @(posedge clock);
		ce <= 1'b1;
		rchk(A_STATUS, 32'h0000_0001, "frozen busy");
		repeat (24) @(posedge clock);
		rchk(A_QUOT, 32'h0000_000E, "thawed quotient");
		rchk(A_REM, 32'h0000_0002, "thawed remainder");
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		n_fail     = 0;
		num_checks = 0;
		rst        = 1'b1;
		ce         = 1'b1;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		sc_reset();
		sc_alu();
		sc_mul();
		sc_div();
		sc_abort();
		sc_freeze();
		give_verdict();
	end
endmodule
